// ---- common/csrc_pkg.sv ----
`default_nettype none
package csrc_pkg;

  // register byte offsets on the bus
  localparam logic [7:0] CSRC_OFS_SYNC_GATE = 8'h00;
  localparam logic [7:0] CSRC_OFS_REF_LADDER = 8'h04;
  localparam logic [7:0] CSRC_OFS_STATUS = 8'h08;

  // comparator_sync_gate_ctrl field positions
  localparam int CSRC_SG_SYNC_BIT = 0;
  localparam int CSRC_SG_GSS_BIT = 1;
  localparam int CSRC_SG_HYS_BIT = 3;
  localparam int CSRC_SG_ALT_BIT = 4;
  localparam logic [7:0] CSRC_SG_WMASK = 8'h1B;
  localparam logic [7:0] CSRC_SG_RESET = 8'h00;

  // reference_ladder_ctrl field positions
  localparam int CSRC_RL_LVL_LSB = 0;
  localparam int CSRC_RL_LVL_W = 4;
  localparam int CSRC_RL_FIXED_REF_ENABLE_BIT = 4;
  localparam int CSRC_RL_RANGE_BIT = 5;
  localparam int CSRC_RL_LEN_BIT = 7;
  localparam logic [7:0] CSRC_RL_WMASK = 8'hBF;
  localparam logic [7:0] CSRC_RL_RESET = 8'h00;

  // status register field positions
  localparam int CSRC_ST_RESULT_BIT = 0;
  localparam int CSRC_ST_LATCH_BIT = 1;
  localparam int CSRC_ST_FIXED_BIT = 2;
  localparam int CSRC_ST_GATE_BIT = 3;

  // timer clock source divide ratios in hclk cycles
  localparam logic [5:0] CSRC_DIV_FOSC = 6'h01;
  localparam logic [5:0] CSRC_DIV_INSTR = 6'h04;

  // ladder tap as a fraction of supply, in 96ths
  localparam logic [7:0] CSRC_TAP_DENOM = 8'h60;
  localparam logic [7:0] CSRC_TAP_HIGH_BASE = 8'h18;
  localparam logic [7:0] CSRC_TAP_LOW_STEP = 8'h04;
  localparam logic [7:0] CSRC_TAP_HIGH_STEP = 8'h03;

  // ahb constants
  localparam logic [2:0] CSRC_HSIZE_WORD = 3'h2;

  typedef enum logic [1:0] {
    CSRC_REF_GND,
    CSRC_REF_LADDER,
    CSRC_REF_FIXED
  } csrc_ref_sel_t;

  // tap numerator over CSRC_TAP_DENOM for a range and level
  function automatic logic [7:0] csrc_tap_num(input logic low_range,
                                              input logic [3:0] lvl);
    logic [7:0] l8;
    l8 = {4'h0, lvl};
    if (low_range) begin
      csrc_tap_num = 8'(l8 * CSRC_TAP_LOW_STEP);
    end else begin
      csrc_tap_num = 8'(CSRC_TAP_HIGH_BASE + l8 * CSRC_TAP_HIGH_STEP);
    end
  endfunction : csrc_tap_num

  // timer clock period in hclk cycles after the prescaler
  function automatic logic [5:0] csrc_period(input logic alt,
                                             input logic [1:0] psel);
    logic [5:0] base;
    base = alt ? CSRC_DIV_FOSC : CSRC_DIV_INSTR;
    csrc_period = 6'(base << psel);
  endfunction : csrc_period

endpackage : csrc_pkg
`default_nettype wire

// ---- src/csrc_hyst.sv ----
`timescale 1ns/100ps
`default_nettype none
module csrc_hyst
  import csrc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hyst_en,
  input wire logic cmp_raw,
  input wire logic cmp_above_hi,
  input wire logic cmp_below_lo,
  output logic cmp_result
);

  typedef struct packed {
    logic result;
  } csrc_hyst_st_t;

  csrc_hyst_st_t st_q;
  csrc_hyst_st_t st_d;

  // output moves only past the thresholds when hysteresis is on
  always_comb begin
    st_d = st_q;
    if (hyst_en) begin
      if (!st_q.result && cmp_above_hi) begin
        st_d.result = 1'b1;
      end else if (st_q.result && cmp_below_lo) begin
        st_d.result = 1'b0;
      end
    end else begin
      st_d.result = cmp_raw;
    end
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign cmp_result = st_q.result;

  AST_HYS_HOLD_LOW: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (hyst_en && !cmp_above_hi && !cmp_result) |=> !cmp_result)
    else $error("output rose without passing upper threshold");

  AST_HYS_HOLD_HIGH: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (hyst_en && !cmp_below_lo && cmp_result) |=> cmp_result)
    else $error("output fell without passing lower threshold");

endmodule : csrc_hyst
`default_nettype wire

// ---- src/csrc_top.sv ----
// Notes on behaviour
// - sync set latches result on timer fall
// - latch uses the prescaled timer clock
// - alt clock picks oscillator, else oscillator/4
// - gate source one picks pin, zero comparator
// - hysteresis field drives hysteresis enable output
// - hysteresis switches only past the thresholds
// - upper three sync register bits read zero
// - ladder enable powers ladder, selects it
// - range one low range, zero high
// - fixed enable turns fixed reference on
// - fast oscillator keeps fixed reference on
// - both enables low deliver ground reference
// - gate source zero lets comparator gate timer
//
// The address map and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module csrc_top
  import csrc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic cmp_raw,
  input wire logic cmp_above_hi,
  input wire logic cmp_below_lo,
  input wire logic external_gate_pin,
  input wire logic [1:0] timer_prescale_sel,
  input wire logic timer_on,
  input wire logic timer_gate_enable,
  input wire logic fast_internal_oscillator,
  output logic timer_clk,
  output logic timer_inc,
  output logic timer_gate,
  output logic timer_count_enable,
  output logic hysteresis_enable,
  output logic ladder_power,
  output csrc_ref_sel_t comparator_ref_input,
  output logic [7:0] ladder_tap,
  output logic fixed_ref_on
);

  typedef struct packed {
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [7:0] sg;
    logic [7:0] rl;
    logic ready;
    logic resp;
    logic [31:0] rdata;
    logic [5:0] ph;
    logic tclk;
    logic rise;
    logic cmp_latch;
    logic gate;
    logic cnt_en;
    logic hys_en;
    logic ladder_pwr;
    csrc_ref_sel_t ref_sel;
    logic [7:0] tap;
    logic fixed_on;
  } csrc_st_t;

  localparam csrc_st_t ST_RESET = '{
    wr_pend: 1'b0,
    wr_addr: 8'h00,
    sg: CSRC_SG_RESET,
    rl: CSRC_RL_RESET,
    ready: 1'b1,
    resp: 1'b0,
    rdata: 32'h0000_0000,
    ph: 6'h00,
    tclk: 1'b1,
    rise: 1'b0,
    cmp_latch: 1'b0,
    gate: 1'b0,
    cnt_en: 1'b0,
    hys_en: 1'b0,
    ladder_pwr: 1'b0,
    ref_sel: CSRC_REF_GND,
    tap: 8'h00,
    fixed_on: 1'b0
  };

  csrc_st_t st_q;
  csrc_st_t st_d;
  logic cmp_result;

  // comparator output with optional hysteresis
  csrc_hyst u_hyst (
    .hclk(hclk),
    .hresetn(hresetn),
    .hyst_en(st_q.sg[CSRC_SG_HYS_BIT]),
    .cmp_raw(cmp_raw),
    .cmp_above_hi(cmp_above_hi),
    .cmp_below_lo(cmp_below_lo),
    .cmp_result(cmp_result)
  );

  // register read mux; unmapped offsets read zero
  function automatic logic [31:0] read_word(input logic [7:0] a,
                                            input logic [7:0] sg,
                                            input logic [7:0] rl,
                                            input logic [7:0] stat);
    if (a == CSRC_OFS_SYNC_GATE) begin
      read_word = {24'h00_0000, sg & CSRC_SG_WMASK};
    end else if (a == CSRC_OFS_REF_LADDER) begin
      read_word = {24'h00_0000, rl & CSRC_RL_WMASK};
    end else if (a == CSRC_OFS_STATUS) begin
      read_word = {24'h00_0000, stat};
    end else begin
      read_word = 32'h0000_0000;
    end
  endfunction : read_word

  logic addr_ok;
  logic [5:0] period;
  logic [5:0] half;
  logic [5:0] half_up;
  logic cmp_eff;
  logic [7:0] stat;

  always_comb begin
    addr_ok = hsel && htrans[1] && hready;
    period = csrc_period(st_q.sg[CSRC_SG_ALT_BIT], timer_prescale_sel);
    half = period >> 1;
    half_up = 6'((period + 6'h01) >> 1);
    // sync field picks the latched or the live result
    cmp_eff = st_q.sg[CSRC_SG_SYNC_BIT] ? st_q.cmp_latch
                                        : cmp_result;
    stat = 8'h00;
    stat[CSRC_ST_RESULT_BIT] = cmp_result;
    stat[CSRC_ST_LATCH_BIT] = st_q.cmp_latch;
    stat[CSRC_ST_FIXED_BIT] = st_q.fixed_on;
    stat[CSRC_ST_GATE_BIT] = st_q.gate;
  end

  // next state of the whole block
  always_comb begin
    st_d = st_q;
    st_d.ready = 1'b1;

    // bus write data phase; only implemented bits change
    if (st_q.wr_pend) begin
      if (st_q.wr_addr == CSRC_OFS_SYNC_GATE) begin
        st_d.sg = hwdata[7:0] & CSRC_SG_WMASK;
      end else if (st_q.wr_addr == CSRC_OFS_REF_LADDER) begin
        st_d.rl = hwdata[7:0] & CSRC_RL_WMASK;
      end
    end

    // bus address phase; read data follow pending writes
    st_d.wr_pend = addr_ok && hwrite && (hsize == CSRC_HSIZE_WORD);
    st_d.wr_addr = haddr[7:0];
    if (addr_ok && !hwrite) begin
      st_d.rdata = read_word(haddr[7:0], st_d.sg, st_d.rl, stat);
    end

    // timer clock phase counter after the prescaler
    if (st_q.ph + 6'h01 >= period) begin
      st_d.ph = 6'h00;
    end else begin
      st_d.ph = st_q.ph + 6'h01;
    end
    st_d.tclk = st_d.ph < half_up;
    st_d.rise = st_d.ph == 6'h00;

    // capture at the falling edge of the prescaled timer clock
    if (st_d.ph == half) begin
      st_d.cmp_latch = cmp_result;
    end

    // timer gate and count enable
    st_d.gate = st_q.sg[CSRC_SG_GSS_BIT] ? external_gate_pin
                                         : cmp_eff;
    st_d.cnt_en = timer_on &&
                  (!timer_gate_enable || st_d.gate);

    // analog control outputs
    st_d.hys_en = st_q.sg[CSRC_SG_HYS_BIT];
    st_d.ladder_pwr = st_q.rl[CSRC_RL_LEN_BIT];
    st_d.fixed_on = st_q.rl[CSRC_RL_FIXED_REF_ENABLE_BIT] ||
                    fast_internal_oscillator;
    if (st_q.rl[CSRC_RL_LEN_BIT]) begin
      st_d.ref_sel = CSRC_REF_LADDER;
    end else if (st_q.rl[CSRC_RL_FIXED_REF_ENABLE_BIT]) begin
      st_d.ref_sel = CSRC_REF_FIXED;
    end else begin
      st_d.ref_sel = CSRC_REF_GND;
    end
    st_d.tap = csrc_tap_num(st_q.rl[CSRC_RL_RANGE_BIT],
      st_q.rl[CSRC_RL_LVL_LSB +: CSRC_RL_LVL_W]);
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= ST_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from the state register
  assign hreadyout = st_q.ready;
  assign hresp = st_q.resp;
  assign hrdata = st_q.rdata;
  assign timer_clk = st_q.tclk;
  assign timer_inc = st_q.rise;
  assign timer_gate = st_q.gate;
  assign timer_count_enable = st_q.cnt_en;
  assign hysteresis_enable = st_q.hys_en;
  assign ladder_power = st_q.ladder_pwr;
  assign comparator_ref_input = st_q.ref_sel;
  assign ladder_tap = st_q.tap;
  assign fixed_ref_on = st_q.fixed_on;

  // helper: cycles since the last timer increment strobe
  logic [5:0] since_rise_q;
  logic [5:0] period_q;
  logic cfg_stable_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      since_rise_q <= 6'h00;
      period_q <= 6'h00;
      cfg_stable_q <= 1'b0;
    end else begin
      since_rise_q <= timer_inc ? 6'h01 : 6'(since_rise_q + 6'h01);
      period_q <= period;
      cfg_stable_q <= timer_inc ? (period_q == period)
                                : (cfg_stable_q && period_q == period);
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  AST_SYNC_HOLD: assert property (
    (st_q.sg[CSRC_SG_SYNC_BIT] && st_d.ph != half)
    |=> $stable(st_q.cmp_latch))
    else $error("latch changed away from the falling edge");

  AST_ASYNC_PASS: assert property (
    (!st_q.sg[CSRC_SG_SYNC_BIT] && !st_q.sg[CSRC_SG_GSS_BIT])
    |=> timer_gate == $past(cmp_result))
    else $error("unsynced comparator result not passed to gate");

  AST_PRESCALE_PERIOD: assert property (
    (timer_inc && cfg_stable_q && since_rise_q != 6'h00 &&
     $past(timer_inc) == 1'b0) |-> since_rise_q == period_q)
    else $error("timer strobe spacing differs from prescaled period");

  AST_FOSC_CLK: assert property (
    (st_q.sg[CSRC_SG_ALT_BIT] && timer_prescale_sel == 2'h0)[*2]
    |=> timer_inc)
    else $error("oscillator clock source not every cycle");

  AST_INSTR_CLK: assert property (
    (timer_inc && !st_q.sg[CSRC_SG_ALT_BIT] &&
     timer_prescale_sel == 2'h0 && st_q.ph == 6'h00)
    ##1 (!st_q.sg[CSRC_SG_ALT_BIT] && timer_prescale_sel == 2'h0)[*3]
    |-> !timer_inc ##1 timer_inc)
    else $error("instruction clock not one in four");

  AST_GATE_PIN: assert property (
    st_q.sg[CSRC_SG_GSS_BIT] |=> timer_gate == $past(external_gate_pin))
    else $error("gate pin not routed to timer gate");

  AST_HYS_OUT: assert property (
    hysteresis_enable == $past(st_q.sg[CSRC_SG_HYS_BIT]))
    else $error("hysteresis enable output not following field");

  AST_SG_UNIMP: assert property (
    (st_q.sg & ~CSRC_SG_WMASK) == 8'h00 && st_q.rl[6] == 1'b0)
    else $error("unimplemented bits hold ones");

  AST_LADDER_SEL: assert property (
    st_q.rl[CSRC_RL_LEN_BIT]
    |=> ladder_power && comparator_ref_input == CSRC_REF_LADDER)
    else $error("ladder enable not powering and selecting ladder");

  AST_TAP_TOP: assert property (
    (st_q.rl[3:0] == 4'hF) |=>
    ladder_tap == ($past(st_q.rl[CSRC_RL_RANGE_BIT]) ? 8'h3C : 8'h45))
    else $error("top ladder tap wrong");

  AST_FIXED_OSC: assert property (
    fast_internal_oscillator |=> fixed_ref_on)
    else $error("fixed reference off while fast oscillator runs");

  AST_GROUND_REF: assert property (
    (!st_q.rl[CSRC_RL_LEN_BIT] && !st_q.rl[CSRC_RL_FIXED_REF_ENABLE_BIT])
    |=> comparator_ref_input == CSRC_REF_GND)
    else $error("ground not delivered with both enables low");

  AST_COUNT_GATE: assert property (
    (timer_on && timer_gate_enable && !st_d.gate)
    |=> !timer_count_enable)
    else $error("timer counting while gate low");

  AST_FIXED_EN: assert property (
    st_q.rl[CSRC_RL_FIXED_REF_ENABLE_BIT] |=> fixed_ref_on)
    else $error("fixed reference off with its enable set");

  AST_LADDER_OFF: assert property (
    !st_q.rl[CSRC_RL_LEN_BIT] |=> !ladder_power)
    else $error("ladder powered with its enable clear");

  AST_TAP_BASE: assert property (
    (st_q.rl[CSRC_RL_LEN_BIT] && st_q.rl[3:0] == 4'h0) |=>
    ladder_tap == ($past(st_q.rl[CSRC_RL_RANGE_BIT]) ? 8'h00 : 8'h18))
    else $error("bottom ladder tap wrong for the range");

  AST_RL_WRITE: assert property (
    (st_q.wr_pend && st_q.wr_addr == CSRC_OFS_REF_LADDER)
    |=> st_q.rl == ($past(hwdata[7:0]) & CSRC_RL_WMASK))
    else $error("ladder register write not confined to its fields");

  AST_BUS_OKAY: assert property (
    hreadyout && !hresp)
    else $error("bus answer not ready and okay");

  COV_SYNC_CAPTURE: cover property (
    st_q.sg[CSRC_SG_SYNC_BIT] && $changed(st_q.cmp_latch));
  COV_PIN_GATE: cover property (
    st_q.sg[CSRC_SG_GSS_BIT] && $rose(timer_gate));
  COV_WRITE_READ: cover property (
    st_q.wr_pend ##1 (st_q.sg != 8'h00));
  COV_HYS_TOGGLE: cover property (
    hysteresis_enable && $changed(cmp_result));

endmodule : csrc_top
`default_nettype wire

// ---- sim/csrc_timer_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module csrc_timer_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic timer_inc,
  input wire logic timer_count_enable,
  output logic [15:0] count
);
  // counts on the rising timer clock pulse, only while allowed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= 16'h0000;
    end else if (timer_inc && timer_count_enable) begin
      count <= count + 16'h0001;
    end
  end
endmodule : csrc_timer_model
`default_nettype wire

// ---- sim/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import csrc_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = CSRC_HSIZE_WORD;
  logic [31:0] hwdata = 32'h0;
  logic hready;
  logic hreadyout, hresp;
  logic [31:0] hrdata;
  logic cmp_raw = 1'b0;
  logic cmp_above_hi = 1'b0;
  logic cmp_below_lo = 1'b0;
  logic external_gate_pin = 1'b0;
  logic [1:0] timer_prescale_sel = 2'h0;
  logic timer_on = 1'b0;
  logic timer_gate_enable = 1'b0;
  logic fast_internal_oscillator = 1'b0;
  logic timer_clk, timer_inc, timer_gate, timer_count_enable;
  logic hysteresis_enable, ladder_power, fixed_ref_on;
  csrc_ref_sel_t comparator_ref_input;
  logic [7:0] ladder_tap;
  logic [15:0] count;
  logic [31:0] v, q;
  logic [31:0] seed = 32'd63452;
  logic [3:0] hs [4] = '{4'h8, 4'hD, 4'h1, 4'h2};
  logic tp;
  int d, c0;
  int miscompares = 0;
  int n_checks = 0;
  assign hready = hreadyout;
  always #2 hclk = ~hclk;
  csrc_top dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .cmp_raw,
    .cmp_above_hi, .cmp_below_lo, .external_gate_pin,
    .timer_prescale_sel, .timer_on, .timer_gate_enable,
    .fast_internal_oscillator, .timer_clk, .timer_inc, .timer_gate,
    .timer_count_enable, .hysteresis_enable, .ladder_power,
    .comparator_ref_input, .ladder_tap, .fixed_ref_on);
  csrc_timer_model tm_u (.hclk, .hresetn, .timer_inc, .timer_count_enable,
    .count);
  // xorshift source of stimulus
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // expected reference selection from register value
  function csrc_ref_sel_t ref_exp(input logic [7:0] r);
    if (r[7]) return CSRC_REF_LADDER;
    if (r[4]) return CSRC_REF_FIXED;
    return CSRC_REF_GND;
  endfunction : ref_exp
  // expected tap in 96ths of supply
  function logic [7:0] tap_exp(input logic [7:0] r);
    return r[5] ? 8'(r[3:0] * 4) : 8'(24 + r[3:0] * 3);
  endfunction : tap_exp
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task results;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results
  // one ahb single transfer, address phase then data phase
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
            output logic [31:0] rd);
    @(posedge hclk);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    hsize <= CSRC_HSIZE_WORD;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : xfer
  task wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] x;
    xfer(1'b1, a, wd, x);
  endtask : wr
  task rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    xfer(1'b0, a, 32'h0, x);
    chk(x, exp);
  endtask : rdc
  task rst;
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(CSRC_OFS_SYNC_GATE, 32'h0);
    rdc(CSRC_OFS_REF_LADDER, 32'h0);
  endtask : rst
  // hang guard
  initial begin
    #200000;
    miscompares++;
    results();
  end
  // main sequence
  initial begin
    rst();
    for (int i = 0; i < 48; i++) begin
      @(posedge hclk);
      v = rnd();
      if (i < 32) v[15:8] = {1'b1, 1'b0, 1'(i / 16), 1'b0, 4'(i)};
      fast_internal_oscillator <= v[16];
      wr(CSRC_OFS_SYNC_GATE, v);
      wr(CSRC_OFS_REF_LADDER, v >> 8);
      rdc(CSRC_OFS_SYNC_GATE, v & 32'(CSRC_SG_WMASK));
      rdc(CSRC_OFS_REF_LADDER, (v >> 8) & 32'(CSRC_RL_WMASK));
      @(negedge hclk);
      chk(32'(hysteresis_enable), 32'(v[3]));
      chk(32'(ladder_power), 32'(v[15]));
      chk(32'(comparator_ref_input), 32'(ref_exp(v[15:8])));
      chk(32'(fixed_ref_on), 32'(v[12] | v[16]));
      if (v[15]) chk(32'(ladder_tap), 32'(tap_exp(v[15:8])));
    end
    wr(8'h0C, 32'hFF);
    chk(32'(hresp), 32'h0);
    rdc(8'h0C, 32'h0);
    rdc(CSRC_OFS_SYNC_GATE, v & 32'(CSRC_SG_WMASK));
    fast_internal_oscillator <= 1'b0;
    wr(CSRC_OFS_REF_LADDER, 32'h20);
    repeat (2) @(negedge hclk);
    chk(32'(ladder_power), 32'h0);
    chk(32'(comparator_ref_input), 32'(CSRC_REF_GND));
    chk(32'(ladder_tap), 32'h0);
    wr(CSRC_OFS_REF_LADDER, 32'h10);
    repeat (8) @(negedge hclk);
    chk(32'(fixed_ref_on), 32'h1);
    chk(32'(comparator_ref_input), 32'(CSRC_REF_FIXED));
    // timer clock period for each source and prescale
    for (int a = 0; a < 2; a++) begin
      for (int p = 0; p < 4; p++) begin
        wr(CSRC_OFS_SYNC_GATE, 32'(a << 4));
        timer_prescale_sel <= 2'(p);
        repeat (40) @(negedge hclk);
        do @(negedge hclk); while (timer_inc !== 1'b1);
        chk(32'(timer_clk), 32'h1);
        d = 0;
        do begin
          @(negedge hclk);
          d++;
        end while (timer_inc !== 1'b1);
        chk(32'(d), 32'((a ? 1 : 4) << p));
      end
    end
    @(posedge hclk);
    timer_prescale_sel <= 2'h0;
    // gate source and count enable combinations
    for (int g = 0; g < 2; g++) begin
      wr(CSRC_OFS_SYNC_GATE, 32'(g << 1));
      for (int k = 0; k < 8; k++) begin
        @(posedge hclk);
        timer_on <= k[0];
        timer_gate_enable <= k[1];
        external_gate_pin <= k[2];
        cmp_raw <= ~k[2];
        repeat (4) @(negedge hclk);
        tp = g ? k[2] : ~k[2];
        chk(32'(timer_gate), 32'(tp));
        chk(32'(timer_count_enable), 32'(k[0] & (~k[1] | tp)));
      end
    end
    // gated counting in the timer model
    wr(CSRC_OFS_SYNC_GATE, 32'h02);
    timer_on <= 1'b1;
    timer_gate_enable <= 1'b1;
    external_gate_pin <= 1'b0;
    repeat (4) @(negedge hclk);
    c0 = int'(count);
    repeat (40) @(negedge hclk);
    chk(32'(count), 32'(c0));
    @(posedge hclk);
    external_gate_pin <= 1'b1;
    repeat (4) @(negedge hclk);
    c0 = int'(count);
    repeat (40) @(negedge hclk);
    d = int'(count) - c0;
    chk(32'(d >= 9 && d <= 11), 32'h1);
    // synchronised gate changes only after a timer clock fall
    @(posedge hclk);
    cmp_raw <= 1'b0;
    wr(CSRC_OFS_SYNC_GATE, 32'h01);
    repeat (20) @(negedge hclk);
    do begin
      tp = timer_clk;
      @(negedge hclk);
    end while (!(tp === 1'b1 && timer_clk === 1'b0));
    @(posedge hclk);
    cmp_raw <= 1'b1;
    repeat (3) @(negedge hclk);
    chk(32'(timer_gate), 32'h0);
    repeat (3) @(negedge hclk);
    chk(32'(timer_gate), 32'h1);
    // hysteresis steps through the thresholds
    @(posedge hclk);
    cmp_raw <= 1'b0;
    cmp_below_lo <= 1'b1;
    wr(CSRC_OFS_SYNC_GATE, 32'h08);
    for (int j = 0; j < 4; j++) begin
      {cmp_raw, cmp_above_hi, cmp_below_lo} <= hs[j][3:1];
      repeat (3) @(posedge hclk);
      xfer(1'b0, CSRC_OFS_STATUS, 32'h0, q);
      chk(32'(q[0]), 32'(hs[j][0]));
    end
    rst();
    results();
  end
endmodule : testbench
`default_nettype wire
